// file: jtbs_buf.sv
// jtbs_buf: two-entry buffer with valid and ready on both sides.
// assumes the same clock and clock enable as the tap.
`timescale 1ns/1ps
`default_nettype none
module jtbs_buf import jtbs_pkg::*; #(
	parameter int W = BSR_W
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic [W-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [W-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	// ==========================================================
	// storage: head drives the output straight from a flop
	logic [W-1:0] tail_r;
	logic [1:0] cnt_r;
	logic [1:0] cnt_nxt;
	logic push;
	logic pop;

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		cnt_nxt = cnt_r;
		if (push && !pop)
			cnt_nxt = cnt_r + 2'h1;
		else if (pop && !push)
			cnt_nxt = cnt_r - 2'h1;
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			cnt_r <= 2'h0;
			in_ready <= 1'h1;
			out_valid <= 1'h0;
		end else if (ce) begin
			cnt_r <= cnt_nxt;
			in_ready <= (cnt_nxt != 2'h2);
			out_valid <= (cnt_nxt != 2'h0);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			out_data <= '0;
			tail_r <= '0;
		end else if (ce) begin
			if (pop && cnt_r == 2'h2)
				out_data <= tail_r;
			else if (push && (cnt_r == 2'h0 || (cnt_r == 2'h1 && pop)))
				out_data <= in_data;
			if (push && cnt_r == 2'h1 && !pop)
				tail_r <= in_data;
		end
	end
endmodule // jtbs_buf
`default_nettype wire

// file: jtbs_host.sv
// jtbs_host: behavioural test controller that drives tck, tms and tdi.
// assumes sys_clk is free running; tck stands low between frames.
`timescale 1ns/1ps
`default_nettype none
module jtbs_host (
	input wire logic sys_clk,
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo,
	input wire logic tdo_oe_n
);
	initial begin
		tck = 1'h0;
		tms = 1'h1;
		tdi = 1'h0;
	end
	// ==========================================================
	// one tck period of 32 sys_clk; tms and tdi move only while tck is low
	task automatic step(input logic m, input logic d, output logic [1:0] q);
		tms = m;
		tdi = d;
		repeat (16) @(negedge sys_clk);
		q = {~tdo_oe_n, tdo};
		tck = 1'h1;
		repeat (16) @(negedge sys_clk);
		tck = 1'h0;
	endtask
	task automatic reset5();
		logic [1:0] q;
		repeat (5) step(1'h1, 1'h0, q);
		step(1'h0, 1'h0, q);
	endtask
	// starts and ends in Run-Test/Idle, lsb first
	task automatic shift(input logic ir, input int n, input logic [31:0] din,
			output logic [31:0] dout, output logic drv);
		logic [1:0] q;
		dout = 32'h0;
		drv = 1'h1;
		step(1'h1, 1'h0, q);
		if (ir)
			step(1'h1, 1'h0, q);
		step(1'h0, 1'h0, q);
		step(1'h0, 1'h0, q);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], q);
			dout[i] = q[0];
			drv &= q[1];
		end
		step(1'h1, 1'h0, q);
		step(1'h0, 1'h0, q);
		tdi = ~tdi;
	endtask
endmodule // jtbs_host
`default_nettype wire

// file: jtbs_pkg.sv
// jtbs_pkg: constants, codes and types for the boundary-scan test port.
// assumes one system clock that is much faster than the test clock.
// How it works
// R1: four pins: clock, data in, data out, mode
// R2: sixteen-state controller held in four bits
// R3: mode level at test-clock rise picks transitions
// R4: reset puts controller in Test-Logic-Reset, no clock
// R5: five mode-high clocks always reach Test-Logic-Reset
// R6: decode EXTEST, SAMPLE/PRELOAD and BYPASS, plus IDCODE
// R7: bypass, identification and boundary registers selectable
// R8: unused or unknown instructions route through bypass
// R9: 32-bit identification: lsb, maker, part, version
// R10: boundary cells observe and control every pin
// R11: controller derives capture, shift, update, select strobes; code has no select strobe
// R12: data out moves on falling edge, else released
`default_nettype none
package jtbs_pkg;

	// ==========================================================
	// sizes
	localparam int NPINS = 8;
	localparam int IR_W = 4;
	localparam int ID_W = 32;
	localparam int BSR_W = 2 * NPINS;
	localparam int HI_RESET_CNT = 5;

	// ==========================================================
	// instruction codes
	localparam logic [IR_W-1:0] INS_EXTEST = 4'h0;
	localparam logic [IR_W-1:0] INS_SAMPLE = 4'h1;
	localparam logic [IR_W-1:0] INS_IDCODE = 4'h2;
	localparam logic [IR_W-1:0] INS_BYPASS = 4'hf;
	localparam logic [IR_W-1:0] IR_CAPT_VAL = 4'h1;

	// ==========================================================
	// identification fields; the values are arbitrary
	localparam logic [3:0] ID_VERSION = 4'h1;
	localparam logic [15:0] ID_PART = 16'h0a5c;
	localparam logic [10:0] ID_MAKER = 11'h123;
	localparam logic ID_LSB = 1'h1;
	localparam logic [ID_W-1:0] ID_VALUE = {ID_VERSION, ID_PART, ID_MAKER, ID_LSB};

	// ==========================================================
	// types
	typedef enum logic [3:0] {
		ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR, ST_EX2_DR,
		ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PA_IR, ST_EX2_IR, ST_UPD_IR
	} jtbs_state_type;

	typedef enum logic [1:0] {SEL_BYPASS, SEL_IDCODE, SEL_BSR} jtbs_sel_type;

	// boundary word: enable cells above data cells
	typedef struct packed {
		logic [NPINS-1:0] oe;
		logic [NPINS-1:0] dat;
	} jtbs_bsr_type;

endpackage
`default_nettype wire

// file: jtbs_tap.sv
// jtbs_tap: test access port, controller, instruction and data registers.
// assumes tck, tms, tdi and pin_in arrive asynchronously; tck is far
// slower than sys_clk so every edge is seen by the sampled copy.
`timescale 1ns/1ps
`default_nettype none
module jtbs_tap import jtbs_pkg::*; (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe_n,
	input wire logic [NPINS-1:0] pin_in,
	input wire logic [NPINS-1:0] core_out,
	input wire logic [NPINS-1:0] core_oe,
	output logic [NPINS-1:0] core_in,
	output logic [NPINS-1:0] pin_out,
	output logic [NPINS-1:0] pin_oe_n,
	output jtbs_bsr_type upd_data,
	output logic upd_valid,
	input wire logic upd_ready
);
	// ==========================================================
	// input synchronisers
	logic tck_s1, tck_s2, tck_s3;
	logic tms_s1, tms_s2;
	logic tdi_s1, tdi_s2;
	logic [NPINS-1:0] pin_s1, pin_s2;
	logic rise, fall;

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			{tck_s1, tck_s2, tck_s3} <= 3'h0;
			{tms_s1, tms_s2, tdi_s1, tdi_s2} <= 4'hf;
			pin_s1 <= '0;
			pin_s2 <= '0;
		end else if (ce) begin
			tck_s1 <= tck; // [R1]
			tck_s2 <= tck_s1;
			tck_s3 <= tck_s2;
			tms_s1 <= tms;
			tms_s2 <= tms_s1;
			tdi_s1 <= tdi;
			tdi_s2 <= tdi_s1;
			pin_s1 <= pin_in;
			pin_s2 <= pin_s1;
		end
	end

	// edges come only from the second and third stages
	assign rise = ce && tck_s2 && !tck_s3;
	assign fall = ce && !tck_s2 && tck_s3;

	// ==========================================================
	// controller
	jtbs_state_type state_r, state_nxt;

	always_comb begin
		unique case (state_r) // [R2]
			ST_TLR: state_nxt = tms_s2 ? ST_TLR : ST_RTI;
			ST_RTI: state_nxt = tms_s2 ? ST_SEL_DR : ST_RTI;
			ST_SEL_DR: state_nxt = tms_s2 ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: state_nxt = tms_s2 ? ST_EX1_DR : ST_SH_DR;
			ST_SH_DR: state_nxt = tms_s2 ? ST_EX1_DR : ST_SH_DR;
			ST_EX1_DR: state_nxt = tms_s2 ? ST_UPD_DR : ST_PA_DR;
			ST_PA_DR: state_nxt = tms_s2 ? ST_EX2_DR : ST_PA_DR;
			ST_EX2_DR: state_nxt = tms_s2 ? ST_UPD_DR : ST_SH_DR;
			ST_UPD_DR: state_nxt = tms_s2 ? ST_SEL_DR : ST_RTI;
			ST_SEL_IR: state_nxt = tms_s2 ? ST_TLR : ST_CAP_IR;
			ST_CAP_IR: state_nxt = tms_s2 ? ST_EX1_IR : ST_SH_IR;
			ST_SH_IR: state_nxt = tms_s2 ? ST_EX1_IR : ST_SH_IR;
			ST_EX1_IR: state_nxt = tms_s2 ? ST_UPD_IR : ST_PA_IR;
			ST_PA_IR: state_nxt = tms_s2 ? ST_EX2_IR : ST_PA_IR;
			ST_EX2_IR: state_nxt = tms_s2 ? ST_UPD_IR : ST_SH_IR;
			ST_UPD_IR: state_nxt = tms_s2 ? ST_SEL_DR : ST_RTI;
		endcase
	end

	// system reset stands in for power-up: no test clock needed
	always_ff @(posedge sys_clk) begin
		if (!resetn)
			state_r <= ST_TLR; // [R4]
		else if (rise)
			state_r <= state_nxt; // [R3] [R5]
	end

	// ==========================================================
	// strobes and instruction decode
	logic cap_ir, sh_ir, upd_ir, cap_dr, sh_dr, upd_dr;
	logic [IR_W-1:0] ir_r, ir_sh_r;
	jtbs_sel_type sel;

	assign cap_ir = rise && state_r == ST_CAP_IR; // [R11]
	assign sh_ir = rise && state_r == ST_SH_IR;
	assign upd_ir = rise && state_r == ST_UPD_IR;
	assign cap_dr = rise && state_r == ST_CAP_DR;
	assign sh_dr = rise && state_r == ST_SH_DR;
	assign upd_dr = rise && state_r == ST_UPD_DR;

	always_comb begin
		unique case (ir_r) // [R6]
			INS_EXTEST: sel = SEL_BSR;
			INS_SAMPLE: sel = SEL_BSR;
			INS_IDCODE: sel = SEL_IDCODE;
			default: sel = SEL_BYPASS; // [R8]
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			ir_r <= INS_IDCODE;
			ir_sh_r <= '0;
		end else if (rise) begin
			if (state_r == ST_TLR)
				ir_r <= INS_IDCODE;
			if (cap_ir)
				ir_sh_r <= IR_CAPT_VAL; // [R11]
			else if (sh_ir)
				ir_sh_r <= {tdi_s2, ir_sh_r[IR_W-1:1]};
			if (upd_ir)
				ir_r <= ir_sh_r;
		end
	end

	// ==========================================================
	// data registers
	logic byp_r;
	logic [ID_W-1:0] id_sh_r;
	logic [BSR_W-1:0] bsr_sh_r;
	jtbs_bsr_type bsr_upd_r;

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			byp_r <= 1'h0;
			id_sh_r <= '0;
			bsr_sh_r <= '0;
		end else if (rise) begin
			if (cap_dr) begin
				byp_r <= 1'h0; // [R7]
				id_sh_r <= ID_VALUE; // [R9]
				bsr_sh_r <= {core_oe, pin_s2}; // [R10]
			end else if (sh_dr) begin
				unique case (sel)
					SEL_BYPASS: byp_r <= tdi_s2; // [R8]
					SEL_IDCODE: id_sh_r <= {tdi_s2, id_sh_r[ID_W-1:1]};
					SEL_BSR: bsr_sh_r <= {tdi_s2, bsr_sh_r[BSR_W-1:1]};
				endcase
			end
		end
	end

	// ==========================================================
	// boundary update word, held until the buffer takes it
	logic upd_pend_r;
	logic buf_ready;

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			bsr_upd_r <= '0;
			upd_pend_r <= 1'h0;
		end else if (ce) begin
			if (upd_dr && sel == SEL_BSR) begin
				bsr_upd_r <= bsr_sh_r; // [R10]
				upd_pend_r <= 1'h1;
			end else if (buf_ready)
				upd_pend_r <= 1'h0;
		end
	end

	jtbs_buf #(
		.W(BSR_W)
	) jtbs_buf_i (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.ce(ce),
		.in_data(bsr_upd_r),
		.in_valid(upd_pend_r),
		.in_ready(buf_ready),
		.out_data(upd_data),
		.out_valid(upd_valid),
		.out_ready(upd_ready)
	);

	// ==========================================================
	// pins: extest drives from the update cells, else the core
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			pin_out <= '0;
			pin_oe_n <= '1;
			core_in <= '0;
		end else if (ce) begin
			core_in <= pin_s2;
			if (ir_r == INS_EXTEST) begin
				pin_out <= bsr_upd_r.dat; // [R10]
				pin_oe_n <= ~bsr_upd_r.oe;
			end else begin
				pin_out <= core_out;
				pin_oe_n <= ~core_oe;
			end
		end
	end

	// ==========================================================
	// serial output, moved on the falling test-clock edge
	logic dr_bit;

	always_comb begin
		unique case (sel)
			SEL_BYPASS: dr_bit = byp_r;
			SEL_IDCODE: dr_bit = id_sh_r[0];
			SEL_BSR: dr_bit = bsr_sh_r[0];
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			tdo <= 1'h0;
			tdo_oe_n <= 1'h1;
		end else if (fall) begin
			tdo <= (state_r == ST_SH_IR) ? ir_sh_r[0] : dr_bit; // [R12]
			tdo_oe_n <= !(state_r == ST_SH_IR || state_r == ST_SH_DR);
		end
	end

	// ==========================================================
	// checks
	logic [2:0] hi_cnt_r;

	always_ff @(posedge sys_clk) begin
		if (!resetn)
			hi_cnt_r <= 3'h0;
		else if (rise)
			hi_cnt_r <= tms_s2 ? ((hi_cnt_r == 3'h7) ? hi_cnt_r : hi_cnt_r + 3'h1) : 3'h0;
	end

	five_high_reset_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R5]
		rise && tms_s2 && hi_cnt_r >= 3'(HI_RESET_CNT - 1) |=> state_r == ST_TLR)
		else $error("five mode-high clocks did not reach reset state");

	reset_state_a: assert property (@(posedge sys_clk) // [R4]
		!resetn |=> state_r == ST_TLR)
		else $error("reset did not place controller in reset state");

	state_on_rise_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R3]
		!rise |=> state_r == $past(state_r))
		else $error("controller moved without a rising test clock");

	tlr_to_idle_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R2]
		rise && state_r == ST_TLR && !tms_s2 |=> state_r == ST_RTI)
		else $error("reset state did not step to idle on mode low");

	tdo_on_fall_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R12]
		$changed(tdo) || $changed(tdo_oe_n) |-> $past(fall))
		else $error("data out changed away from a falling edge");

	tdo_release_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R12]
		fall && state_r != ST_SH_IR && state_r != ST_SH_DR |=> tdo_oe_n)
		else $error("data out driven outside a shift state");

	ir_capture_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R11]
		cap_ir |=> ir_sh_r == IR_CAPT_VAL)
		else $error("instruction capture pattern wrong");

	id_capture_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R9]
		cap_dr && sel == SEL_IDCODE |=> id_sh_r == ID_VALUE && id_sh_r[0])
		else $error("identification capture wrong");

	bypass_path_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R8]
		fall && state_r == ST_SH_DR && ir_r != INS_EXTEST && ir_r != INS_SAMPLE
		&& ir_r != INS_IDCODE |=> tdo == $past(byp_r))
		else $error("unknown instruction did not use bypass");

	extest_drive_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [R10]
		ce && ir_r == INS_EXTEST |=> pin_out == $past(bsr_upd_r.dat))
		else $error("pins not driven from update cells in extest");

endmodule // jtbs_tap
`default_nettype wire

// file: jtbs_tap_tb_top.sv
// jtbs_tap_tb_top: self-checking bench for the test access port.
// assumes jtbs_host plays the outside controller; ce is held high except for one test-clock period near the end.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
	$display("mismatch %s expected %h seen %h", nm, e, g); end end
module jtbs_tap_tb_top import jtbs_pkg::*;;
	logic sys_clk = 1'h0, resetn = 1'h0, tck, tms, tdi, tdo, tdo_oe_n, upd_valid;
	logic upd_ready = 1'h0, stall = 1'h0, ce = 1'h1;
	logic [NPINS-1:0] pin_in = 8'h0, core_out = 8'h0, core_oe = 8'h0;
	logic [NPINS-1:0] core_in, pin_out, pin_oe_n;
	jtbs_bsr_type upd_data, w, e;
	jtbs_bsr_type exp_q[$];
	int num_errors = 0, n_compared = 0, seed = 90349;
	logic [31:0] r, d;
	logic o;
	logic [1:0] q;
	always #2.5 sys_clk = ~sys_clk;
	jtbs_host jtbs_host_i (.sys_clk(sys_clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
		.tdo_oe_n(tdo_oe_n));
	jtbs_tap jtbs_tap_i (.sys_clk(sys_clk), .resetn(resetn), .ce(ce), .tck(tck), .tms(tms),
		.tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .pin_in(pin_in), .core_out(core_out),
		.core_oe(core_oe), .core_in(core_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.upd_data(upd_data), .upd_valid(upd_valid), .upd_ready(upd_ready));
	always @(negedge sys_clk)
		upd_ready <= stall ? 1'h0 : 1'($random(seed));
	// ==========================================================
	// update stream monitor: each accepted word takes the oldest note
	always @(posedge sys_clk) begin
		if (resetn && upd_valid === 1'h1 && upd_ready === 1'h1) begin
			e = exp_q.size() > 0 ? exp_q.pop_front() : ~upd_data;
			`CHK("upd_data", e, upd_data)
		end
	end
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic load_ir(input logic [IR_W-1:0] c);
		jtbs_host_i.shift(1'h1, IR_W, {28'h0, c}, r, o);
		`CHK("ir capture", IR_CAPT_VAL, r[3:0])
		repeat (8) @(negedge sys_clk);
		`CHK("tdo released", 1'h1, tdo_oe_n)
	endtask
	// boundary shift with a random preload word; the update word is noted
	task automatic bsr_shift();
		w = jtbs_bsr_type'(16'($random(seed)));
		exp_q.push_back(w);
		jtbs_host_i.shift(1'h0, BSR_W, {16'h0, w}, r, o);
	endtask
	initial begin
		#450000;
		num_errors++;
		final_report();
	end
	initial begin
		repeat (4) @(negedge sys_clk);
		resetn = 1'h1;
		repeat (4) @(negedge sys_clk);
		`CHK("tdo_oe_n", 1'h1, tdo_oe_n)
		`CHK("pin_oe_n", 8'hff, pin_oe_n)
		jtbs_host_i.step(1'h0, 1'h0, q);
		jtbs_host_i.shift(1'h0, ID_W, 32'h0, r, o);
		`CHK("idcode", ID_VALUE, r)
		`CHK("tdo driven", 1'h1, o)
		for (int c = 3; c < 16; c++) begin
			load_ir(4'(c));
			d = $random(seed);
			jtbs_host_i.shift(1'h0, 32, d, r, o);
			`CHK("bypass", {d[30:0], 1'h0}, r)
		end
		{pin_in, core_oe, core_out} = 24'($random(seed));
		load_ir(INS_SAMPLE);
		`CHK("core_in", pin_in, core_in)
		`CHK("pin_out", core_out, pin_out)
		`CHK("pin_oe_n", ~core_oe, pin_oe_n)
		stall = 1'h1;
		repeat (3) begin
			bsr_shift();
			`CHK("bsr capture", {core_oe, pin_in}, r[15:0])
		end
		`CHK("upd_valid", 1'h1, upd_valid)
		stall = 1'h0;
		repeat (40) @(negedge sys_clk);
		`CHK("drained", 0, exp_q.size())
		load_ir(INS_EXTEST);
		`CHK("extest out", w.dat, pin_out)
		`CHK("extest oe", ~w.oe, pin_oe_n)
		bsr_shift();
		repeat (40) @(negedge sys_clk);
		`CHK("extest upd", w.dat, pin_out)
		// abandon a data shift midway, then five high tms clocks; the way out
		// passes Update-DR, so the capture shifted by a 1 then a 0 is offered
		exp_q.push_back({2'h1, core_oe, pin_in[7:2]});
		jtbs_host_i.step(1'h1, 1'h0, q);
		repeat (3) jtbs_host_i.step(1'h0, 1'h1, q);
		jtbs_host_i.reset5();
		// a test-clock period spent with ce low must leave the controller idle
		repeat (4) @(negedge sys_clk);
		ce = 1'h0;
		jtbs_host_i.step(1'h1, 1'h0, q);
		ce = 1'h1;
		jtbs_host_i.shift(1'h0, ID_W, 32'h0, r, o);
		`CHK("idcode after reset", ID_VALUE, r)
		`CHK("pin_out after reset", core_out, pin_out)
		`CHK("abandon drained", 0, exp_q.size())
		final_report();
	end
endmodule // jtbs_tap_tb_top
`default_nettype wire
